// File: rtl/motor_temp_params.svh
// Constants for the motor temperature monitor: mode codes, field layout,
// fault code and timing counts.
// Assumes a 100 MHz ref_clk; included by its bare name.
`ifndef MOTOR_TEMP_PARAMS_SVH
`define MOTOR_TEMP_PARAMS_SVH

// ==========================================================
// Operation mode codes
`define MT_MODE_OFF 8'd0
`define MT_MODE_PTC_WARN 8'd111
`define MT_MODE_PTC_FAULT 8'd112
`define MT_MODE_PTC_1MIN 8'd113
`define MT_MODE_PTC_5MIN 8'd114
`define MT_MODE_PTC_10MIN 8'd115
`define MT_MODE_KTY_WARN 8'd121
`define MT_MODE_KTY_FAULT 8'd122
`define MT_MODE_KTY_1MIN 8'd123
`define MT_MODE_KTY_5MIN 8'd124
`define MT_MODE_KTY_10MIN 8'd125
`define MT_MODE_PT_WARN 8'd131
`define MT_MODE_PT_FAULT 8'd132
`define MT_MODE_PT_1MIN 8'd133
`define MT_MODE_PT_5MIN 8'd134
`define MT_MODE_PT_10MIN 8'd135

// ==========================================================
// Fault reporting and status words
`define MT_FAULT_CODE 16'h0400
`define MT_NO_FAULT 16'h0000
`define MT_WORD_RESET 16'h0000
`define MT_IN_USED_BITS 12

// ==========================================================
// Timing
`define MT_CLK_HZ 100000000
`define MT_TICK_S 1
`define MT_TICK_CYCLES (`MT_CLK_HZ * `MT_TICK_S)
`define MT_DELAY_SHORT_MIN 1
`define MT_DELAY_MID_MIN 5
`define MT_DELAY_LONG_MIN 10
`define MT_S_PER_MIN 60
`define MT_DELAY_SHORT_TICKS (`MT_DELAY_SHORT_MIN * `MT_S_PER_MIN / `MT_TICK_S)
`define MT_DELAY_MID_TICKS (`MT_DELAY_MID_MIN * `MT_S_PER_MIN / `MT_TICK_S)
`define MT_DELAY_LONG_TICKS (`MT_DELAY_LONG_MIN * `MT_S_PER_MIN / `MT_TICK_S)

`endif

// File: rtl/motor_temp_pkg.sv
// Types shared by the motor temperature monitor and its delay timer.
// Assumes motor_temp_params.svh supplies the numeric constants.
package motor_temp_pkg;

	// ==========================================================
	// Decoded operating mode
	typedef enum {
		SRC_NONE,
		SRC_PTC,
		SRC_KTY,
		SRC_PT1000
	} sensor_sel_t;

	typedef enum {
		ACT_OFF,
		ACT_WARN,
		ACT_FAULT
	} action_t;

	typedef struct packed {
		logic [1:0] src;
		logic [1:0] act;
		logic delayed;
		logic [15:0] delay_ticks;
	} mode_cfg_t;

	// ==========================================================
	// Digital input states, packed in status word order (bit 0 last)
	typedef struct packed {
		logic multifunction_input_two;
		logic multifunction_input_three;
		logic remote_input_two;
		logic remote_input_one;
		logic multifunction_input_four;
		logic multifunction_input_one;
		logic digital_input_six;
		logic digital_input_five;
		logic digital_input_four;
		logic digital_input_three;
		logic digital_input_two;
		logic safe_torque_off_input;
	} din_states_t;

	// Sensor evaluation results from the expansion_sensor_terminal front end
	typedef struct packed {
		logic pt1000_overtemp;
		logic kty_overtemp;
		logic ptc_overtemp;
	} sensor_flags_t;

	typedef struct packed {
		logic [15:0] count;
		logic expired;
	} timer_state_t;

endpackage : motor_temp_pkg

// File: rtl/delay_timer.sv
// Shutdown delay counter: counts tick pulses while run is high.
// Assumes tick is a one-cycle enable from a prescaler on the same clock.
`timescale 1ns/1ps
`default_nettype none

module delay_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic run,
	input wire logic [15:0] limit,
	output logic expired
);
	import motor_temp_pkg::*;

	timer_state_t st_reg;
	timer_state_t st_next;

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		if (!run) begin
			st_next.count = 16'h0000;
			st_next.expired = 1'b0;
		end else if (tick && !st_reg.expired) begin
			if (st_reg.count >= limit - 16'h0001) begin
				st_next.expired = 1'b1;
			end else begin
				st_next.count = st_reg.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign expired = st_reg.expired;

endmodule : delay_timer

`default_nettype wire

// File: rtl/motor_temp_monitor.sv
// Motor temperature supervision and digital signal status words.
// Assumes sensor flags and inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

`include "motor_temp_params.svh"

module motor_temp_monitor #(
	parameter int unsigned TICK_CYCLES = `MT_TICK_CYCLES,
	parameter logic [15:0] SHORT_TICKS = 16'(`MT_DELAY_SHORT_TICKS),
	parameter logic [15:0] MID_TICKS = 16'(`MT_DELAY_MID_TICKS),
	parameter logic [15:0] LONG_TICKS = 16'(`MT_DELAY_LONG_TICKS)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] op_mode,
	input wire motor_temp_pkg::sensor_flags_t sensor_flags,
	input wire logic program_ack,
	input wire logic error_ack_input,
	input wire motor_temp_pkg::din_states_t din_states,
	input wire logic [15:0] dout_states,
	output logic warning_flag,
	output logic fault_shutdown,
	output logic [15:0] fault_code,
	output logic red_led,
	output logic [15:0] input_status_word,
	output logic [15:0] output_status_word
);
	import motor_temp_pkg::*;

	// ==========================================================
	// Module state
	typedef struct packed {
		logic [31:0] prescale;
		logic tick;
		logic ack_prev;
		logic fault;
		logic warn;
		logic led;
		logic [15:0] code;
		logic [15:0] in_word;
		logic [15:0] out_word;
	} mon_state_t;

	mon_state_t st_reg;
	mon_state_t st_next;

	mode_cfg_t cfg;
	logic overtemp;
	logic timer_run;
	logic timer_expired;
	logic ack_event;
	logic fault_set;

	// ==========================================================
	// Mode decode
	function automatic mode_cfg_t decode_mode(input logic [7:0] mode);
		mode_cfg_t c;
		c.src = 2'(SRC_NONE);
		c.act = 2'(ACT_OFF);
		c.delayed = 1'b0;
		c.delay_ticks = 16'h0000;
		unique case (mode)
			`MT_MODE_PTC_WARN: begin
				c.src = 2'(SRC_PTC);
				c.act = 2'(ACT_WARN);
			end
			`MT_MODE_PTC_FAULT,
			`MT_MODE_PTC_1MIN,
			`MT_MODE_PTC_5MIN,
			`MT_MODE_PTC_10MIN: begin
				c.src = 2'(SRC_PTC);
				c.act = 2'(ACT_FAULT);
			end
			`MT_MODE_KTY_WARN: begin
				c.src = 2'(SRC_KTY);
				c.act = 2'(ACT_WARN);
			end
			`MT_MODE_KTY_FAULT,
			`MT_MODE_KTY_1MIN,
			`MT_MODE_KTY_5MIN,
			`MT_MODE_KTY_10MIN: begin
				c.src = 2'(SRC_KTY);
				c.act = 2'(ACT_FAULT);
			end
			`MT_MODE_PT_WARN: begin
				c.src = 2'(SRC_PT1000);
				c.act = 2'(ACT_WARN);
			end
			`MT_MODE_PT_FAULT,
			`MT_MODE_PT_1MIN,
			`MT_MODE_PT_5MIN,
			`MT_MODE_PT_10MIN: begin
				c.src = 2'(SRC_PT1000);
				c.act = 2'(ACT_FAULT);
			end
			default: begin
				// Mode 0 and unsupported codes evaluate nothing
				c.src = 2'(SRC_NONE);
				c.act = 2'(ACT_OFF);
			end
		endcase
		unique case (mode)
			`MT_MODE_PTC_1MIN,
			`MT_MODE_KTY_1MIN,
			`MT_MODE_PT_1MIN: begin
				c.delayed = 1'b1;
				c.delay_ticks = SHORT_TICKS;
			end
			`MT_MODE_PTC_5MIN,
			`MT_MODE_KTY_5MIN,
			`MT_MODE_PT_5MIN: begin
				c.delayed = 1'b1;
				c.delay_ticks = MID_TICKS;
			end
			`MT_MODE_PTC_10MIN,
			`MT_MODE_KTY_10MIN,
			`MT_MODE_PT_10MIN: begin
				c.delayed = 1'b1;
				c.delay_ticks = LONG_TICKS;
			end
			default: begin
				c.delayed = 1'b0;
			end
		endcase
		return c;
	endfunction : decode_mode

	assign cfg = decode_mode(op_mode);

	// ==========================================================
	// Sensor selection
	always_comb begin
		unique case (cfg.src)
			2'(SRC_PTC): overtemp = sensor_flags.ptc_overtemp;
			2'(SRC_KTY): overtemp = sensor_flags.kty_overtemp;
			2'(SRC_PT1000): overtemp = sensor_flags.pt1000_overtemp;
			default: overtemp = 1'b0;
		endcase
	end

	// ==========================================================
	// Shutdown delay
	assign timer_run = overtemp && cfg.delayed && (cfg.act == 2'(ACT_FAULT));

	delay_timer u_delay_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(st_reg.tick),
		.run(timer_run),
		.limit(cfg.delay_ticks),
		.expired(timer_expired)
	);

	// ==========================================================
	// Fault latch controls
	assign ack_event = program_ack || (error_ack_input && !st_reg.ack_prev);
	assign fault_set = overtemp && (cfg.act == 2'(ACT_FAULT))
		&& (!cfg.delayed || timer_expired);

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.prescale >= TICK_CYCLES - 1) begin
			st_next.prescale = 32'h0000_0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.prescale = st_reg.prescale + 32'h0000_0001;
		end
		st_next.ack_prev = error_ack_input;
		// Set wins over a simultaneous acknowledge
		if (fault_set) begin
			st_next.fault = 1'b1;
		end else if (ack_event) begin
			st_next.fault = 1'b0;
		end
		st_next.code = st_next.fault ? `MT_FAULT_CODE : `MT_NO_FAULT;
		st_next.warn = overtemp && (cfg.act == 2'(ACT_WARN));
		st_next.led = overtemp;
		st_next.in_word = {{(16 - `MT_IN_USED_BITS){1'b0}}, din_states};
		st_next.out_word = dout_states;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.code <= `MT_NO_FAULT;
			st_reg.in_word <= `MT_WORD_RESET;
			st_reg.out_word <= `MT_WORD_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign warning_flag = st_reg.warn;
	assign fault_shutdown = st_reg.fault;
	assign fault_code = st_reg.code;
	assign red_led = st_reg.led;
	assign input_status_word = st_reg.in_word;
	assign output_status_word = st_reg.out_word;

endmodule : motor_temp_monitor

`default_nettype wire

// File: verification/motor_temp_checker.sv
// Port assertions for the motor temperature monitor.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none

module motor_temp_checker #(
	parameter int unsigned TICK_CYCLES = 4,
	parameter logic [15:0] SHORT_TICKS = 16'h2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] op_mode,
	input wire motor_temp_pkg::sensor_flags_t sensor_flags,
	input wire logic program_ack,
	input wire logic warning_flag,
	input wire logic fault_shutdown,
	input wire logic [15:0] fault_code,
	input wire logic red_led,
	input wire logic [15:0] input_status_word
);
	import motor_temp_pkg::*;
	localparam longint MINC = longint'(SHORT_TICKS - 16'h1) * TICK_CYCLES;
	localparam longint MAXC = longint'(SHORT_TICKS) * TICK_CYCLES + 3;
	longint hot_reg;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Consecutive hot cycles in the one-minute PTC mode
	always_ff @(posedge ref_clk) begin
		if (rst || !(op_mode == 8'h71 && sensor_flags.ptc_overtemp))
			hot_reg <= 0;
		else
			hot_reg <= hot_reg + 1;
	end
	sequence cool_ack;
		(sensor_flags == 3'h0)[*3] ##0 program_ack;
	endsequence
	// ==========================================================
	quiet_off_a: assert property (op_mode == 8'h00 |=>
		!warning_flag && !red_led && !$rose(fault_shutdown)) else $error("off mode active");
	imm_fault_a: assert property ((op_mode == 8'h70 && sensor_flags.ptc_overtemp) ||
		(op_mode == 8'h7a && sensor_flags.kty_overtemp) |=> fault_shutdown && fault_code == 16'h0400)
		else $error("no immediate fault");
	code_match_a: assert property (fault_code == (fault_shutdown ? 16'h0400 : 16'h0000))
		else $error("fault code wrong");
	warn_only_a: assert property (op_mode == 8'h79 && sensor_flags.kty_overtemp |=>
		warning_flag && !$rose(fault_shutdown)) else $error("warning mode wrong");
	led_on_a: assert property (op_mode == 8'h7a && sensor_flags.kty_overtemp |=> red_led)
		else $error("red led not lit");
	led_drop_a: assert property (op_mode == 8'h7a && sensor_flags == 3'h0 |=> !red_led)
		else $error("red led stuck");
	ack_clear_a: assert property (cool_ack |=> !fault_shutdown)
		else $error("ack ignored");
	delay_late_a: assert property (hot_reg >= MAXC |-> fault_shutdown)
		else $error("delayed fault late");
	delay_early_a: assert property ($rose(fault_shutdown) && hot_reg != 0 |-> hot_reg >= MINC)
		else $error("delayed fault early");
	upper_zero_a: assert property (input_status_word[15:12] == 4'h0)
		else $error("upper bits set");
endmodule : motor_temp_checker

`default_nettype wire

// File: verification/sensor_model.sv
// Sensor front end stand-in: raises the flag of the selected sensor.
// Assumes hot and sel are driven from ref_clk by the bench.
`timescale 1ns/1ps
`default_nettype none

module sensor_model (
	input wire logic ref_clk,
	input wire logic hot,
	input wire logic [1:0] sel,
	output var motor_temp_pkg::sensor_flags_t flags
);
	import motor_temp_pkg::*;
	initial flags = sensor_flags_t'(3'h0);
	always @(posedge ref_clk) begin
		flags <= hot ? sensor_flags_t'(3'(3'h1 << sel)) : sensor_flags_t'(3'h0);
	end
endmodule : sensor_model

`default_nettype wire

// File: verification/motor_temp_monitor_tb.sv
// Self-checking bench for the motor temperature monitor.
// Assumes design, checker and sensor model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "motor_temp_params.svh"

module motor_temp_monitor_tb;
	import motor_temp_pkg::*;
	localparam int T = 4;
	int lims[3] = '{2, 3, 4};
	int modes[17] = '{0, 111, 112, 113, 114, 115, 121, 122, 123, 124, 125, 131, 132, 133,
		134, 135, 77};
	logic ref_clk = 0;
	logic rst = 1;
	logic [7:0] op_mode = '0;
	logic hot = 0;
	logic [1:0] sel = '0;
	sensor_flags_t flags;
	logic program_ack = 0;
	logic error_ack_input = 0;
	din_states_t din_states = '0;
	logic [15:0] dout_states = '0;
	logic warning_flag, fault_shutdown, red_led;
	logic [15:0] fault_code, in_word, out_word;
	logic [15:0] in_q[$], out_q[$];
	int fails = 0, checks = 0, cycles = 0, kind, sub;

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	motor_temp_monitor #(.TICK_CYCLES(T), .SHORT_TICKS(16'h2), .MID_TICKS(16'h3),
		.LONG_TICKS(16'h4)) i_dut (.ref_clk(ref_clk), .rst(rst), .op_mode(op_mode),
		.sensor_flags(flags), .program_ack(program_ack), .error_ack_input(error_ack_input),
		.din_states(din_states), .dout_states(dout_states), .warning_flag(warning_flag),
		.fault_shutdown(fault_shutdown), .fault_code(fault_code), .red_led(red_led),
		.input_status_word(in_word), .output_status_word(out_word));
	sensor_model i_sensor (.ref_clk(ref_clk), .hot(hot), .sel(sel), .flags(flags));

	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// ==========================================================
	// Status words against a queue model
	initial begin
		void'($urandom(53));
		forever begin
			@(posedge ref_clk);
			if (in_q.size() > 0) chk("in word", in_word, in_q.pop_front());
			if (out_q.size() > 0) chk("out word", out_word, out_q.pop_front());
			in_q.push_back(rst ? 16'h0 : {4'h0, din_states});
			out_q.push_back(rst ? 16'h0 : dout_states);
			din_states <= din_states_t'(12'($urandom));
			dout_states <= 16'($urandom);
		end
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			close_out();
		end
	end

	// ==========================================================
	// Every mode: heat, check, cool, acknowledge
	initial begin
		cyc(4);
		rst <= 1'b0;
		for (int i = 0; i < 17; i++) begin
			sub = modes[i] % 10;
			kind = (modes[i] / 10 inside {[11:13]} && sub inside {[1:5]}) ? sub : 0;
			op_mode <= 8'(modes[i]);
			sel <= (kind != 0) ? 2'(modes[i] / 10 - 11) : 2'h0;
			hot <= 1'b1;
			cyc(4);
			chk("fault", 16'(fault_shutdown), 16'(kind == 2));
			chk("warn", 16'(warning_flag), 16'(kind == 1));
			chk("led", 16'(red_led), 16'(kind != 0));
			if (kind >= 3) begin
				cyc(lims[kind - 3] * T + 2);
				chk("late fault", 16'(fault_shutdown), 16'h1);
			end
			if (kind >= 2) chk("code", fault_code, `MT_FAULT_CODE);
			hot <= 1'b0;
			cyc(4);
			chk("led off", 16'(red_led), 16'h0);
			if (i % 2)
				program_ack <= 1'b1;
			else
				error_ack_input <= 1'b1;
			cyc(1);
			program_ack <= 1'b0;
			error_ack_input <= 1'b0;
			cyc(2);
			chk("cleared", 16'(fault_shutdown), 16'h0);
			chk("code off", fault_code, `MT_NO_FAULT);
		end
		op_mode <= 8'h7b;
		sel <= 2'h1;
		repeat (3) begin
			hot <= 1'b1;
			cyc(3);
			hot <= 1'b0;
			cyc(1);
		end
		cyc(6);
		chk("restart", 16'(fault_shutdown), 16'h0);
		close_out();
	end
endmodule : motor_temp_monitor_tb

bind motor_temp_monitor motor_temp_checker #(.TICK_CYCLES(TICK_CYCLES),
	.SHORT_TICKS(SHORT_TICKS)) i_chk (.ref_clk(ref_clk), .rst(rst), .op_mode(op_mode),
	.sensor_flags(sensor_flags), .program_ack(program_ack), .warning_flag(warning_flag),
	.fault_shutdown(fault_shutdown), .fault_code(fault_code), .red_led(red_led),
	.input_status_word(input_status_word));

`default_nettype wire
